// file: rsir_pkg.sv
// package: constants and types for the relay setting and input routing block
package rsir_pkg;

	// ****************************************************************
	// apb register map
	// ****************************************************************
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_ROUTE    = 8'h04;
	localparam logic [7:0]  ADDR_PASSWORD = 8'h08;
	localparam logic [7:0]  ADDR_DISPLAY  = 8'h0C;
	localparam logic [7:0]  ADDR_SETTING  = 8'h10;
	localparam logic [7:0]  ADDR_STATUS   = 8'h14;
	localparam logic [7:0]  ADDR_MEAS     = 8'h18;
	localparam logic [31:0] SLVERR_DATA   = 32'h0000_0000;

	// ctrl field positions
	localparam int CTRL_FLASH_OFF = 0;
	localparam int CTRL_SCALE_SEC = 1;
	localparam int CTRL_BLOCK_LO  = 4;
	localparam int CTRL_BLOCK_HI  = 7;

	// ****************************************************************
	// setting items, display and counts
	// ****************************************************************
	localparam logic [3:0]  NUM_MEAS_ITEMS = 4'h4;
	localparam logic [3:0]  NUM_SET_ITEMS  = 4'h4;
	localparam logic [15:0] PASSWORD_RST   = 16'h1234;
	localparam logic [7:0]  FREQ_50        = 8'h32;
	localparam logic [7:0]  FREQ_60        = 8'h3C;
	localparam logic [7:0]  DELAY_MAX      = 8'hC8;
	localparam logic [7:0]  DELAY_RST      = 8'h0A;
	localparam logic [7:0]  PICKUP_RST     = 8'h7D;
	localparam logic [7:0]  SEC_PRIM_RST   = 8'h01;
	localparam logic [7:0]  FLASH_HALF     = 8'h04;
	localparam int          NUM_STAGES     = 4;

	// item index inside the setting part of the sequence
	localparam logic [3:0] ITEM_FREQ  = 4'h0;
	localparam logic [3:0] ITEM_CHAR  = 4'h1;
	localparam logic [3:0] ITEM_DELAY = 4'h2;
	localparam logic [3:0] ITEM_FLASH = 4'h3;

	// reminder time before the automatic delay fallback
	localparam longint CLK_HZ        = 10_000_000;
	localparam longint REMIND_SEC    = 300;
	localparam longint REMIND_CYCLES = REMIND_SEC * CLK_HZ;
	localparam longint FAST_HZ       = 4;
	localparam longint FAST_CYCLES   = CLK_HZ / FAST_HZ;

	typedef enum logic [2:0] {
		RSIR_SOFT_SET_ONE,
		RSIR_SOFT_SET_TWO,
		RSIR_BLOCK_SELECTS_SET,
		RSIR_RESET_SELECTS_SET,
		RSIR_BLOCK_TRIGGERS_REC,
		RSIR_RESET_TRIGGERS_REC,
		RSIR_COMBINED_SWITCH_REC
	} rsir_route_t;

	typedef enum logic [2:0] {
		RSIR_DEFINITE,
		RSIR_NORMAL_INV,
		RSIR_VERY_INV,
		RSIR_EXTREME_INV,
		RSIR_RI_INV,
		RSIR_LONG_INV
	} rsir_curve_t;

	// fastest-tripping delay code for each curve
	function automatic logic [7:0] rsir_fastest(input rsir_curve_t c);
		case (c)
			RSIR_DEFINITE:    rsir_fastest = 8'h00;
			RSIR_NORMAL_INV:  rsir_fastest = 8'h05;
			RSIR_VERY_INV:    rsir_fastest = 8'h05;
			RSIR_EXTREME_INV: rsir_fastest = 8'h05;
			RSIR_RI_INV:      rsir_fastest = 8'h05;
			RSIR_LONG_INV:    rsir_fastest = 8'h05;
			default:          rsir_fastest = 8'h00;
		endcase
	endfunction : rsir_fastest

endpackage : rsir_pkg

// file: rsir_relay_setting.sv
// design: front-panel setting controller and external-input routing
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// ********************************************************************
// What this block does
// - select/reset steps display: measured values first, then settings.
// - front-panel setting changes refused until the correct password is entered.
// - secondary scaling shows current as multiple of rated secondary.
// - nominal frequency is 50 or 60, changed by plus/minus, committed.
// - untripped pickup that drops back flashes stage LED until reset.
// - flash-off option suppresses that activation flashing.
// - software set modes: software picks set; inputs block and reset.
// - block-input-switch mode: block input selects set, reset stays.
// - reset-input-switch mode: reset input selects set, block stays.
// - block-input-recorder mode: block input starts recorder at once.
// - recorder LED lit for whole recording after external start.
// - reset-input-recorder mode: reset input starts recorder.
// - combined mode: block input selects set two, reset starts recorder.
// - reset input used as set switch performs no reset.
// - block input blocks only the software-selected functions.
// - low-set pickup is setting times nominal current.
// - six curves cycled with plus/minus, stored with enter.
// - after curve stored, go to delay item; delay LED flashes only if the stored curve differs.
// - curve changed, delay untouched: fastest delay after five minutes.
// - delay out of range blocks the low-set element.
// - out-of-range blocking leaves the alarm relay working.
// ********************************************************************
module rsir_relay_setting #(
	parameter longint REMIND_CYCLES_P = rsir_pkg::REMIND_CYCLES,
	parameter longint FAST_CYCLES_P   = rsir_pkg::FAST_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        keySelect,
	input  wire logic        keyPlus,
	input  wire logic        keyMinus,
	input  wire logic        keyEnter,
	input  wire logic        blockInput,
	input  wire logic        resetInput,
	input  wire logic [rsir_pkg::NUM_STAGES-1:0] stagePickup,
	input  wire logic [rsir_pkg::NUM_STAGES-1:0] stageTrip,
	input  wire logic        recorderBusy,
	input  wire logic        lowSetPickup,
	input  wire logic        alarmRequest,
	output logic [rsir_pkg::NUM_STAGES-1:0] stageLed,
	output logic             recorderLed,
	output logic             recorderStart,
	output logic             paramSetTwo,
	output logic             relayReset,
	output logic [rsir_pkg::NUM_STAGES-1:0] functionBlock,
	output logic             lowSetBlock,
	output logic             alarmRelay,
	output logic             delayLedFlash,
	output logic [15:0]      lowSetThreshold,
	output logic [7:0]       nominalFreq,
	output logic [7:0]       displayValue
);
	import rsir_pkg::*;

	// ****************************************************************
	// register state
	// ****************************************************************
	logic [7:0]  ctrl;
	rsir_route_t route;
	logic [15:0] password;
	logic        unlocked;
	logic [7:0]  measValue;
	logic [7:0]  secPrimRatio;
	logic [7:0]  pickupSetting;
	logic [7:0]  delaySetting;
	logic [7:0]  nominalInCode;
	logic [3:0]  dispIndex;
	rsir_curve_t curve;
	rsir_curve_t editCurve;
	logic [7:0]  editFreq;
	logic        curveChanged;
	logic        delayTouched;
	logic [31:0] remindCount;
	logic [31:0] flashCount;
	logic        flashPhase;
	logic [NUM_STAGES-1:0] stagePicked;
	logic [NUM_STAGES-1:0] stageFlash;
	logic        blockPrev;
	logic        resetPrev;
	logic        recRunning;

	logic apbWrite;
	logic apbRead;
	logic inSettings;
	logic [3:0] setItem;
	logic blockRouted;
	logic resetRouted;
	logic blockToRec;
	logic resetToRec;
	logic blockToSet;
	logic resetToSet;
	logic extTrigger;
	logic delayOutOfRange;
	logic keyReset;

	assign apbWrite = psel && penable && pwrite;
	assign apbRead  = psel && !penable && !pwrite;
	assign inSettings = dispIndex >= NUM_MEAS_ITEMS;
	assign setItem  = dispIndex - NUM_MEAS_ITEMS;
	assign delayOutOfRange = delaySetting > DELAY_MAX;
	assign keyReset = keySelect && !inSettings;

	function automatic logic knownAddr(input logic [7:0] a);
		knownAddr = (a <= ADDR_MEAS) && (a[1:0] == 2'b00);
	endfunction : knownAddr

	// ****************************************************************
	// input routing
	// ****************************************************************
	always_comb begin
		blockToSet = (route == RSIR_BLOCK_SELECTS_SET) ||
			(route == RSIR_COMBINED_SWITCH_REC);
		resetToSet = route == RSIR_RESET_SELECTS_SET;
		blockToRec = route == RSIR_BLOCK_TRIGGERS_REC;
		resetToRec = (route == RSIR_RESET_TRIGGERS_REC) ||
			(route == RSIR_COMBINED_SWITCH_REC);
		blockRouted = !(blockToSet || blockToRec);
		resetRouted = !(resetToSet || resetToRec);
		// a raised input means auxiliary voltage is present
		extTrigger = (blockToRec && blockInput && !blockPrev) ||
			(resetToRec && resetInput && !resetPrev);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			blockPrev     <= 1'b0;
			resetPrev     <= 1'b0;
			paramSetTwo   <= 1'b0;
			relayReset    <= 1'b0;
			functionBlock <= '0;
			recorderStart <= 1'b0;
			recRunning    <= 1'b0;
			recorderLed   <= 1'b0;
		end else begin
			blockPrev <= blockInput;
			resetPrev <= resetInput;
			if (blockToSet)
				paramSetTwo <= blockInput;
			else if (resetToSet)
				paramSetTwo <= resetInput;
			else
				paramSetTwo <= route == RSIR_SOFT_SET_TWO;
			relayReset <= (resetRouted && resetInput) || keyReset;
			functionBlock <= (blockRouted && blockInput) ?
				ctrl[CTRL_BLOCK_HI:CTRL_BLOCK_LO] : '0;
			recorderStart <= extTrigger;
			if (extTrigger)
				recRunning <= 1'b1;
			else if (recorderStart == 1'b0 && !recorderBusy)
				recRunning <= 1'b0;
			recorderLed <= extTrigger || recRunning;
		end
	end

	// ****************************************************************
	// front-panel keys
	// ****************************************************************
	logic remindDone;
	assign remindDone = curveChanged && !delayTouched &&
		(remindCount >= 32'(REMIND_CYCLES_P - 1));

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dispIndex    <= 4'h0;
			editFreq     <= FREQ_50;
			nominalFreq  <= FREQ_50;
			editCurve    <= RSIR_DEFINITE;
			curve        <= RSIR_DEFINITE;
			delaySetting <= DELAY_RST;
			curveChanged <= 1'b0;
			delayTouched <= 1'b0;
		end else begin
			if (keySelect)
				dispIndex <= (dispIndex == NUM_MEAS_ITEMS +
					NUM_SET_ITEMS - 4'h1) ? 4'h0 :
					dispIndex + 4'h1;
			if (remindDone) begin
				delaySetting <= rsir_fastest(curve);
				curveChanged <= 1'b0;
			end
			// keys only edit while unlocked
			if (inSettings && unlocked) begin
				case (setItem)
					ITEM_FREQ: begin
						if (keyPlus || keyMinus)
							editFreq <= (editFreq == FREQ_50) ?
								FREQ_60 : FREQ_50;
						if (keyEnter)
							nominalFreq <= editFreq;
					end
					ITEM_CHAR: begin
						if (keyPlus)
							editCurve <= (editCurve == RSIR_LONG_INV) ?
								RSIR_DEFINITE :
								rsir_curve_t'(editCurve + 3'h1);
						else if (keyMinus)
							editCurve <= (editCurve == RSIR_DEFINITE) ?
								RSIR_LONG_INV :
								rsir_curve_t'(editCurve - 3'h1);
						if (keyEnter) begin
							curve        <= editCurve;
							curveChanged <= editCurve != curve;
							delayTouched <= 1'b0;
							dispIndex    <= NUM_MEAS_ITEMS + ITEM_DELAY;
						end
					end
					ITEM_DELAY: begin
						if (keyPlus && delaySetting != 8'hFF) begin
							delaySetting <= delaySetting + 8'h01;
							delayTouched <= 1'b1;
						end else if (keyMinus && delaySetting != 8'h00) begin
							delaySetting <= delaySetting - 8'h01;
							delayTouched <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// reminder and flash timing
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			remindCount <= '0;
		else if (!curveChanged || delayTouched || remindDone)
			remindCount <= '0;
		else
			remindCount <= remindCount + 32'h1;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flashCount <= '0;
			flashPhase <= 1'b0;
		end else if (flashCount >= 32'(FAST_CYCLES_P - 1)) begin
			flashCount <= '0;
			flashPhase <= !flashPhase;
		end else begin
			flashCount <= flashCount + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			delayLedFlash <= 1'b0;
		else
			delayLedFlash <= curveChanged && !delayTouched &&
				flashPhase;
	end

	// ****************************************************************
	// activation storage
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			stagePicked <= '0;
			stageFlash  <= '0;
			stageLed    <= '0;
		end else begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				if (stageTrip[i])
					stagePicked[i] <= 1'b0;
				else if (stagePickup[i])
					stagePicked[i] <= 1'b1;
				else
					stagePicked[i] <= 1'b0;
				// set beats reset so a drop-out in a reset cycle stays
				if (stagePicked[i] && !stagePickup[i] && !stageTrip[i] &&
					!ctrl[CTRL_FLASH_OFF])
					stageFlash[i] <= 1'b1;
				else if (relayReset || ctrl[CTRL_FLASH_OFF])
					stageFlash[i] <= 1'b0;
				stageLed[i] <= stagePickup[i] || stageTrip[i] ||
					(stageFlash[i] && flashPhase);
			end
		end
	end

	// ****************************************************************
	// protection outputs and display
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			lowSetBlock     <= 1'b0;
			alarmRelay      <= 1'b0;
			lowSetThreshold <= '0;
			displayValue    <= '0;
		end else begin
			lowSetBlock <= delayOutOfRange;
			alarmRelay  <= alarmRequest;
			lowSetThreshold <= pickupSetting * nominalInCode;
			if (!inSettings)
				displayValue <= ctrl[CTRL_SCALE_SEC] ? measValue :
					8'(measValue * secPrimRatio);
			else
				case (setItem)
					ITEM_FREQ:  displayValue <= editFreq;
					ITEM_CHAR:  displayValue <= {5'h00, editCurve};
					ITEM_DELAY: displayValue <= delaySetting;
					ITEM_FLASH: displayValue <= {7'h00, ctrl[CTRL_FLASH_OFF]};
					default:    displayValue <= 8'h00;
				endcase
		end
	end

	// ****************************************************************
	// apb slave: zero wait, slverr on unmapped address
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl          <= 8'h00;
			route         <= RSIR_SOFT_SET_ONE;
			password      <= PASSWORD_RST;
			unlocked      <= 1'b0;
			secPrimRatio  <= SEC_PRIM_RST;
			pickupSetting <= PICKUP_RST;
			nominalInCode <= 8'h01;
			measValue     <= 8'h00;
		end else if (apbWrite && knownAddr(paddr)) begin
			case (paddr)
				ADDR_CTRL:     ctrl <= pwdata[7:0];
				ADDR_ROUTE:    route <= rsir_route_t'(pwdata[2:0]);
				ADDR_PASSWORD: unlocked <= pwdata[15:0] == password;
				ADDR_SETTING:  begin
					pickupSetting <= pwdata[7:0];
					secPrimRatio  <= pwdata[15:8];
					nominalInCode <= pwdata[23:16];
				end
				ADDR_MEAS:     measValue <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !knownAddr(paddr);
			if (apbRead)
				case (paddr)
					ADDR_CTRL:     prdata <= {24'h0, ctrl};
					ADDR_ROUTE:    prdata <= {29'h0, route};
					ADDR_PASSWORD: prdata <= {31'h0, unlocked};
					ADDR_DISPLAY:  prdata <= {20'h0, dispIndex, displayValue};
					ADDR_SETTING:  prdata <= {8'h0, nominalInCode,
						secPrimRatio, pickupSetting};
					ADDR_STATUS:   prdata <= {16'h0, nominalFreq,
						curveChanged, lowSetBlock, recorderLed,
						paramSetTwo, 1'b0, curve};
					ADDR_MEAS:     prdata <= {24'h0, measValue};
					default:       prdata <= SLVERR_DATA;
				endcase
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	chk_reset_switch_noreset: assert property (@(posedge clk_sys)
		disable iff (sys_rst) resetToSet && !keyReset |=> !relayReset)
		else $error("reset performed while reset input switches set");
	chk_block_selects_set: assert property (@(posedge clk_sys)
		disable iff (sys_rst) blockToSet |=> paramSetTwo == $past(blockInput))
		else $error("block input did not select set");
	chk_reset_selects_set: assert property (@(posedge clk_sys)
		disable iff (sys_rst) resetToSet |=> paramSetTwo == $past(resetInput))
		else $error("reset input did not select set");
	chk_block_starts_rec: assert property (@(posedge clk_sys)
		disable iff (sys_rst) blockToRec && $rose(blockInput) |=>
		recorderStart && recorderLed)
		else $error("block input did not start recorder");
	chk_reset_starts_rec: assert property (@(posedge clk_sys)
		disable iff (sys_rst) resetToRec && $rose(resetInput) |=>
		recorderStart)
		else $error("reset input did not start recorder");
	chk_rec_led_hold: assert property (@(posedge clk_sys)
		disable iff (sys_rst) recRunning && recorderBusy |=> recorderLed)
		else $error("recorder led dropped during recording");
	chk_locked_no_edit: assert property (@(posedge clk_sys)
		disable iff (sys_rst) !unlocked && !remindDone |=>
		$stable(delaySetting) && $stable(nominalFreq))
		else $error("setting changed while locked");
	chk_exit_blocks_low: assert property (@(posedge clk_sys)
		disable iff (sys_rst) delayOutOfRange |=> lowSetBlock)
		else $error("low set not blocked on out-of-range delay");
	chk_alarm_unblocked: assert property (@(posedge clk_sys)
		disable iff (sys_rst) alarmRequest |=> alarmRelay)
		else $error("alarm relay blocked");
	chk_freq_two_values: assert property (@(posedge clk_sys)
		disable iff (sys_rst) nominalFreq == FREQ_50 || nominalFreq == FREQ_60)
		else $error("nominal frequency not 50 or 60");

	cov_curve_store: cover property (@(posedge clk_sys)
		disable iff (sys_rst) keyEnter && inSettings && setItem == ITEM_CHAR
		&& unlocked);
	cov_fallback: cover property (@(posedge clk_sys)
		disable iff (sys_rst) remindDone);
	cov_ext_record: cover property (@(posedge clk_sys)
		disable iff (sys_rst) recorderStart);

endmodule : rsir_relay_setting

// file: rsir_operator.sv
// operator model: front-panel pushbuttons and field wiring of both inputs
`timescale 1ns/100ps
module rsir_operator (
	input  wire logic clk_sys,
	output logic      keySelect,
	output logic      keyPlus,
	output logic      keyMinus,
	output logic      keyEnter,
	output logic      blockInput,
	output logic      resetInput
);
	initial begin
		{keySelect, keyPlus, keyMinus, keyEnter} = 4'h0;
		blockInput = 1'b0;
		resetInput = 1'b0;
	end
	// one-cycle press: 0 select, 1 plus, 2 minus, 3 enter
	task automatic press(input int k);
		@(posedge clk_sys);
		case (k)
			0: keySelect <= 1'b1;
			1: keyPlus <= 1'b1;
			2: keyMinus <= 1'b1;
			default: keyEnter <= 1'b1;
		endcase
		@(posedge clk_sys);
		{keySelect, keyPlus, keyMinus, keyEnter} <= 4'h0;
		// one idle edge so the key's effect has landed on return
		@(posedge clk_sys);
	endtask : press
	// high level stands for auxiliary voltage on the terminal
	task automatic wire_in(input logic b, input logic r);
		@(posedge clk_sys);
		blockInput <= b;
		resetInput <= r;
	endtask : wire_in
endmodule : rsir_operator

// file: testbench.sv
// testbench: self-checking run of the setting and routing block
`timescale 1ns/100ps
module testbench;
	import rsir_pkg::*;
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, nominalFreq, displayValue;
	logic [31:0] pwdata, prdata, rd;
	logic keySelect, keyPlus, keyMinus, keyEnter, blockInput, resetInput;
	logic [3:0] stagePickup, stageTrip, stageLed, functionBlock;
	logic recorderBusy, alarmRequest, recorderLed, recorderStart;
	logic lowSetPickup;
	logic paramSetTwo, relayReset, lowSetBlock, alarmRelay, delayLedFlash;
	logic [15:0] lowSetThreshold;
	logic err, sawStart, sawFlash;
	int n_errors, checked;

	rsir_relay_setting #(.REMIND_CYCLES_P(20), .FAST_CYCLES_P(2)) uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .keySelect(keySelect), .keyPlus(keyPlus),
		.keyMinus(keyMinus), .keyEnter(keyEnter),
		.blockInput(blockInput), .resetInput(resetInput),
		.stagePickup(stagePickup), .stageTrip(stageTrip),
		.recorderBusy(recorderBusy), .lowSetPickup(lowSetPickup),
		.alarmRequest(alarmRequest), .stageLed(stageLed),
		.recorderLed(recorderLed), .recorderStart(recorderStart),
		.paramSetTwo(paramSetTwo), .relayReset(relayReset),
		.functionBlock(functionBlock), .lowSetBlock(lowSetBlock),
		.alarmRelay(alarmRelay), .delayLedFlash(delayLedFlash),
		.lowSetThreshold(lowSetThreshold), .nominalFreq(nominalFreq),
		.displayValue(displayValue));
	rsir_operator op (.clk_sys(clk_sys), .keySelect(keySelect),
		.keyPlus(keyPlus), .keyMinus(keyMinus), .keyEnter(keyEnter),
		.blockInput(blockInput), .resetInput(resetInput));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// pulses are too short to poll from the tasks
	always @(posedge clk_sys) begin
		if (recorderStart === 1'b1) sawStart <= 1'b1;
		if (delayLedFlash === 1'b1) sawFlash <= 1'b1;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic final_report();
		$display("compares %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic stage_toggles(input int s, output int n);
		logic last;
		n = 0;
		last = stageLed[s];
		repeat (12) begin
			@(posedge clk_sys);
			if (stageLed[s] !== last) n++;
			last = stageLed[s];
		end
	endtask : stage_toggles

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_edit();
		cmp(nominalFreq, FREQ_50);
		apb(1'b0, 8'h1C, 0);
		cmp(err, 1);
		apb(1'b0, ADDR_PASSWORD, 0);
		cmp(rd[0], 0);
		repeat (4) op.press(0);
		op.press(1);
		op.press(3);
		cmp(nominalFreq, FREQ_50);
		apb(1'b1, ADDR_PASSWORD, 32'h0000_1111);
		apb(1'b0, ADDR_PASSWORD, 0);
		cmp(rd[0], 0);
		apb(1'b1, ADDR_PASSWORD, {16'h0, PASSWORD_RST});
		apb(1'b0, ADDR_PASSWORD, 0);
		cmp(rd[0], 1);
		op.press(1);
		op.press(3);
		cmp(nominalFreq, FREQ_60);
		$display("test edit done");
	endtask : t_edit
	task automatic t_curve();
		int i;
		op.press(0);
		sawFlash = 1'b0;
		op.press(2);
		op.press(1);
		op.press(1);
		op.press(3);
		repeat (10) @(posedge clk_sys);
		cmp(sawFlash, 1);
		cmp(displayValue, DELAY_RST);
		repeat (60) @(posedge clk_sys);
		apb(1'b0, ADDR_STATUS, 0);
		cmp(rd[2:0], RSIR_NORMAL_INV);
		cmp(displayValue, 8'h05);
		alarmRequest <= 1'b1;
		for (i = 0; i < 200; i++) op.press(1);
		repeat (3) @(posedge clk_sys);
		cmp(lowSetBlock, 1);
		cmp(alarmRelay, 1);
		for (i = 0; i < 5; i++) op.press(2);
		repeat (3) @(posedge clk_sys);
		cmp(lowSetBlock, 0);
		$display("test curve done");
	endtask : t_curve
	task automatic t_scale();
		apb(1'b1, ADDR_MEAS, 32'h0000_0007);
		apb(1'b1, ADDR_SETTING, 32'h0004_037D);
		repeat (2) op.press(0);
		repeat (2) @(posedge clk_sys);
		cmp(displayValue, 8'h15);
		cmp(lowSetThreshold, 16'h01F4);
		apb(1'b1, ADDR_CTRL, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		cmp(displayValue, 8'h07);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		$display("test scale done");
	endtask : t_scale
	task automatic t_flash();
		int n;
		apb(1'b1, ADDR_ROUTE, 0);
		stagePickup <= 4'h1;
		repeat (3) @(posedge clk_sys);
		stagePickup <= 4'h0;
		stage_toggles(0, n);
		cmp(n >= 2, 1);
		op.wire_in(1'b0, 1'b1);
		op.wire_in(1'b0, 1'b0);
		repeat (4) @(posedge clk_sys);
		stage_toggles(0, n);
		cmp({n[7:0], 3'h0, stageLed[0]}, 0);
		stagePickup <= 4'h4;
		repeat (2) @(posedge clk_sys);
		stageTrip <= 4'h4;
		@(posedge clk_sys);
		{stagePickup, stageTrip} <= 8'h00;
		repeat (2) @(posedge clk_sys);
		stage_toggles(2, n);
		cmp({n[7:0], 3'h0, stageLed[2]}, 0);
		apb(1'b1, ADDR_CTRL, 32'h0000_0051);
		stagePickup <= 4'h2;
		repeat (3) @(posedge clk_sys);
		stagePickup <= 4'h0;
		repeat (2) @(posedge clk_sys);
		stage_toggles(1, n);
		cmp({n[7:0], 3'h0, stageLed[1]}, 0);
		$display("test flash done");
	endtask : t_flash
	task automatic t_route();
		// per mode {set two, blocks, resets, records}
		logic [3:0] ex[7] = '{4'h6, 4'hE, 4'hA, 4'hC, 4'h3, 4'h5, 4'h9};
		int m;
		apb(1'b1, ADDR_CTRL, 32'h0000_0050);
		for (m = 0; m < 7; m++) begin
			apb(1'b1, ADDR_ROUTE, m);
			recorderBusy <= 1'b1;
			sawStart <= 1'b0;
			op.wire_in(1'b1, 1'b1);
			repeat (4) @(posedge clk_sys);
			cmp(paramSetTwo, ex[m][3]);
			cmp(functionBlock, ex[m][2] ? 4'h5 : 4'h0);
			cmp(relayReset, ex[m][1]);
			cmp(sawStart, ex[m][0]);
			cmp(recorderLed, ex[m][0]);
			recorderBusy <= 1'b0;
			op.wire_in(1'b0, 1'b0);
			repeat (4) @(posedge clk_sys);
		end
		$display("test route done");
	endtask : t_route

	initial begin
		{psel, penable, pwrite, recorderBusy, alarmRequest} = 5'h0;
		{sawStart, sawFlash} = 2'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		stagePickup = 4'h0;
		stageTrip = 4'h0;
		lowSetPickup = 1'b0;
		n_errors = 0;
		checked = 0;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_edit();
		t_curve();
		t_scale();
		t_flash();
		t_route();
		final_report();
	end
endmodule : testbench
